// ### hw/primary_serial_port.sv
`timescale 1ns/1ps
`include "psp_defs.svh"
module primary_serial_port #(
  parameter int RX_DEPTH = 2
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Host I/O port
  input  wire logic [9:0] io_addr_i,
  input  wire logic       io_rd_i,
  input  wire logic       io_wr_i,
  input  wire logic [7:0] io_wdata_i,
  output logic      [7:0] io_rdata_o,
  output logic            irq_o,
  // Serial line
  output logic            txd_o,
  input  wire logic       rxd_i,
  // Modem lines, active low
  input  wire logic       cts_n_i,
  input  wire logic       dsr_n_i,
  input  wire logic       ri_n_i,
  input  wire logic       dcd_n_i,
  output logic            dtr_n_o,
  output logic            rts_n_o,
  output logic            out1_n_o,
  output logic            out2_n_o
);

  typedef struct packed {
    logic [7:0]             thr;
    logic                   thr_full;
    logic [7:0]             dl_lo;
    logic [7:0]             dl_hi;
    logic [3:0]             ier;
    psp_pkg::line_fmt_type  lcr;
    psp_pkg::modem_ctl_type mcr;
    logic                   oe;
    logic                   pe;
    logic                   fe;
    logic                   bi;
    logic                   thre_irq;
    logic [3:0]             msd;
    logic [3:0]             mprev;
    logic [15:0]            pre;
    psp_pkg::tx_state_type  ts;
    logic [5:0]             tt;
    logic [2:0]             tb;
    logic [7:0]             tsh;
    logic                   tpar;
    psp_pkg::rx_state_type  rs;
    logic [3:0]             rt;
    logic [2:0]             rb;
    logic [7:0]             rsh;
    logic                   rpar;
    logic                   rprev;
    logic                   txd;
    logic                   dtr_n;
    logic                   rts_n;
    logic                   out1_n;
    logic                   out2_n;
    logic                   irq;
    logic [7:0]             rdata;
  } state_type;

  state_type             s;
  state_type             next_s;
  logic [15:0]           div;
  logic                  tick;
  logic [2:0]            last;
  logic [5:0]            stop_len;
  logic                  tline;
  logic                  rin;
  logic [3:0]            mnow;
  logic [3:0]            mdelta;
  logic [7:0]            rx_data;
  logic                  ls_p;
  logic                  rda_p;
  logic                  th_p;
  logic                  ms_p;
  logic                  pend;
  logic [1:0]            iid;
  logic                  rx_push;
  logic                  thre_set;
  psp_pkg::rx_char_type  push_char;
  psp_pkg::rx_char_type  buf_out;
  logic                  buf_in_ready;
  logic                  buf_out_valid;
  logic                  pop;
  logic                  rd_data;
  logic                  rd_ier;
  logic                  rd_iir;
  logic                  rd_lsr;
  logic                  rd_msr;

  // Parity bit for a character under the current format
  function automatic logic par_bit(input logic [7:0] d, input psp_pkg::line_fmt_type f);
    logic [7:0] m;
    m = 8'hFF >> (2'h3 - f.wlen);
    return f.stick ? ~f.even : (^(d & m) ^ ~f.even);
  endfunction

  // Baud tick every divisor clocks, sixteen ticks per bit
  assign div  = {s.dl_hi, s.dl_lo};
  assign tick = ({1'b0, s.pre} + 17'h00001) >= {1'b0, div};
  // Index of the last data bit: code 0..3 gives 5..8 bits
  assign last = 3'(3'h4 + {1'b0, s.lcr.wlen});
  assign stop_len = !s.lcr.stop2 ? `STOP_ONE :
                    (s.lcr.wlen == 2'h0) ? `STOP_ONEH : `STOP_TWO;

  // Serial level presented by the transmitter
  assign tline = (s.ts == psp_pkg::tx_start) ? 1'b0 :
                 (s.ts == psp_pkg::tx_data)  ? s.tsh[0] :
                 (s.ts == psp_pkg::tx_par)   ? s.tpar : 1'b1;
  // Loopback feeds the transmitter back into the receiver
  assign rin  = s.mcr.loop ? (tline & ~s.lcr.brk) : rxd_i;
  assign mnow = s.mcr.loop ? ~{s.mcr.out2, s.mcr.out1, s.mcr.dtr, s.mcr.rts}
                           : {dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
  // Changes, ring only on its trailing edge
  assign mdelta = {mnow[3] ^ s.mprev[3], mnow[2] & ~s.mprev[2],
                   mnow[1] ^ s.mprev[1], mnow[0] ^ s.mprev[0]};
  assign rx_data = s.rsh >> (2'h3 - s.lcr.wlen);

  // Pending sources in priority order
  assign ls_p  = s.ier[2] & (s.oe | s.pe | s.fe | s.bi);
  assign rda_p = s.ier[0] & buf_out_valid;
  assign th_p  = s.ier[1] & s.thre_irq;
  assign ms_p  = s.ier[3] & (|s.msd);
  assign pend  = ls_p | rda_p | th_p | ms_p;
  assign iid   = ls_p ? `IID_LINE : rda_p ? `IID_RXDAT :
                 th_p ? `IID_THRE : `IID_MODEM;

  // Read decode
  assign rd_data = io_rd_i && io_addr_i == `ADDR_DATA;
  assign rd_ier  = io_rd_i && io_addr_i == `ADDR_IER;
  assign rd_iir  = io_rd_i && io_addr_i == `ADDR_IIR;
  assign rd_lsr  = io_rd_i && io_addr_i == `ADDR_LSR;
  assign rd_msr  = io_rd_i && io_addr_i == `ADDR_MSR;
  assign pop     = rd_data & ~s.lcr.divisor_access_select & buf_out_valid;

  // Received characters wait here until software reads them
  char_buffer #(
    .WIDTH ($bits(psp_pkg::rx_char_type)),
    .DEPTH (RX_DEPTH)
  ) char_buffer_inst (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rx_push),
    .in_data_i   (push_char),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (buf_out_valid),
    .out_data_o  (buf_out),
    .out_ready_i (pop)
  );

  // Next state of the whole port
  always_comb begin
    next_s    = s;
    rx_push   = 1'b0;
    thre_set  = 1'b0;
    push_char = '0;
    next_s.pre   = tick ? 16'h0000 : 16'(s.pre + 16'h0001);
    next_s.rprev = rin;
    next_s.mprev = mnow;

    // Transmitter
    if (s.ts != psp_pkg::tx_idle && tick) begin
      next_s.tt = 6'(s.tt + 6'h01);
    end
    unique case (s.ts)
      psp_pkg::tx_idle: begin
        if (s.thr_full) begin
          next_s.tsh      = s.thr;
          next_s.tpar     = par_bit(s.thr, s.lcr);
          next_s.thr_full = 1'b0;
          thre_set        = 1'b1;
          next_s.tt       = 6'h00;
          next_s.ts       = psp_pkg::tx_start;
        end
      end
      psp_pkg::tx_start: begin
        if (tick && s.tt == `BIT_LAST) begin
          next_s.tt = 6'h00;
          next_s.tb = 3'h0;
          next_s.ts = psp_pkg::tx_data;
        end
      end
      psp_pkg::tx_data: begin
        if (tick && s.tt == `BIT_LAST) begin
          next_s.tsh = s.tsh >> 1;
          next_s.tb  = 3'(s.tb + 3'h1);
          next_s.tt  = 6'h00;
          if (s.tb == last) begin
            next_s.ts = s.lcr.pen ? psp_pkg::tx_par : psp_pkg::tx_stop;
          end
        end
      end
      psp_pkg::tx_par: begin
        if (tick && s.tt == `BIT_LAST) begin
          next_s.tt = 6'h00;
          next_s.ts = psp_pkg::tx_stop;
        end
      end
      psp_pkg::tx_stop: begin
        if (tick && s.tt == 6'(stop_len - 6'h01)) begin
          next_s.ts = psp_pkg::tx_idle;
        end
      end
    endcase

    // Receiver, sampling each bit at its middle
    if (s.rs != psp_pkg::rx_idle && tick) begin
      next_s.rt = 4'(s.rt + 4'h1);
    end
    unique case (s.rs)
      psp_pkg::rx_idle: begin
        if (s.rprev && !rin) begin
          next_s.rt = 4'h0;
          next_s.rs = psp_pkg::rx_start;
        end
      end
      psp_pkg::rx_start: begin
        if (tick && s.rt == `HALF_LAST) begin
          next_s.rt = 4'h0;
          next_s.rb = 3'h0;
          next_s.rs = rin ? psp_pkg::rx_idle : psp_pkg::rx_data;
        end
      end
      psp_pkg::rx_data: begin
        if (tick && s.rt == 4'hF) begin
          next_s.rsh = {rin, s.rsh[7:1]};
          next_s.rb  = 3'(s.rb + 3'h1);
          next_s.rt  = 4'h0;
          if (s.rb == last) begin
            next_s.rs = s.lcr.pen ? psp_pkg::rx_par : psp_pkg::rx_stop;
          end
        end
      end
      psp_pkg::rx_par: begin
        if (tick && s.rt == 4'hF) begin
          next_s.rpar = rin;
          next_s.rt   = 4'h0;
          next_s.rs   = psp_pkg::rx_stop;
        end
      end
      psp_pkg::rx_stop: begin
        if (tick && s.rt == 4'hF) begin
          push_char.data = rx_data;
          push_char.fe   = ~rin;
          push_char.pe   = s.lcr.pen & (s.rpar != par_bit(rx_data, s.lcr));
          push_char.brk  = ~rin & (rx_data == 8'h00) & ~(s.lcr.pen & s.rpar);
          rx_push        = 1'b1;
          next_s.rs      = psp_pkg::rx_idle;
        end
      end
    endcase

    // Register writes
    if (io_wr_i) begin
      unique case (io_addr_i)
        `ADDR_DATA: begin
          if (s.lcr.divisor_access_select) begin
            next_s.dl_lo = io_wdata_i;
          end else begin
            next_s.thr      = io_wdata_i;
            next_s.thr_full = 1'b1;
            next_s.thre_irq = 1'b0;
          end
        end
        `ADDR_IER: begin
          if (s.lcr.divisor_access_select) begin
            next_s.dl_hi = io_wdata_i;
          end else begin
            next_s.ier = io_wdata_i[3:0];
            if (io_wdata_i[1] && !s.ier[1] && !s.thr_full) begin
              thre_set = 1'b1;
            end
          end
        end
        `ADDR_LCR: next_s.lcr = io_wdata_i;
        `ADDR_MCR: next_s.mcr = io_wdata_i[4:0];
        default: ;
      endcase
    end

    // Register reads; flags cleared by a read
    if (io_rd_i) begin
      unique case (io_addr_i)
        `ADDR_DATA: next_s.rdata = s.lcr.divisor_access_select ? s.dl_lo : buf_out.data;
        `ADDR_IER:  next_s.rdata = s.lcr.divisor_access_select ? s.dl_hi : {4'h0, s.ier};
        `ADDR_IIR: begin
          next_s.rdata = {5'h00, iid, ~pend};
          if (pend && iid == `IID_THRE) begin
            next_s.thre_irq = 1'b0;
          end
        end
        `ADDR_LCR:  next_s.rdata = s.lcr;
        `ADDR_MCR:  next_s.rdata = {3'h0, s.mcr};
        `ADDR_LSR: begin
          next_s.rdata = {1'b0, ~s.thr_full & (s.ts == psp_pkg::tx_idle), ~s.thr_full,
                          s.bi, s.fe, s.pe, s.oe, buf_out_valid};
          next_s.oe = 1'b0;
          next_s.pe = 1'b0;
          next_s.fe = 1'b0;
          next_s.bi = 1'b0;
        end
        `ADDR_MSR: begin
          next_s.rdata = {s.mprev, s.msd};
          next_s.msd   = 4'h0;
        end
        default: next_s.rdata = 8'h00;
      endcase
    end

    // Hardware events set after any clear, so they are never lost
    if (thre_set) begin
      next_s.thre_irq = 1'b1;
    end
    if (rx_push) begin
      next_s.oe = next_s.oe | ~buf_in_ready;
      next_s.pe = next_s.pe | push_char.pe;
      next_s.fe = next_s.fe | push_char.fe;
      next_s.bi = next_s.bi | push_char.brk;
    end
    next_s.msd = next_s.msd | mdelta;

    // Registered pins
    next_s.txd    = s.lcr.brk ? 1'b0 : (s.mcr.loop | tline);
    next_s.dtr_n  = ~s.mcr.dtr | s.mcr.loop;
    next_s.rts_n  = ~s.mcr.rts | s.mcr.loop;
    next_s.out1_n = ~s.mcr.out1 | s.mcr.loop;
    next_s.out2_n = ~s.mcr.out2 | s.mcr.loop;
    next_s.irq    = pend;

    if (!rst_n_i) begin
      next_s        = '0;
      next_s.dl_lo  = 8'(`DIV_RESET & 16'h00FF);
      next_s.dl_hi  = 8'(`DIV_RESET >> 8);
      next_s.ier    = `IER_RESET;
      next_s.mcr    = `MCR_RESET;
      next_s.mprev  = `MSR_IDLE;
      next_s.ts     = psp_pkg::tx_idle;
      next_s.rs     = psp_pkg::rx_idle;
      next_s.rprev  = 1'b1;
      next_s.txd    = 1'b1;
      next_s.dtr_n  = 1'b1;
      next_s.rts_n  = 1'b1;
      next_s.out1_n = 1'b1;
      next_s.out2_n = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  // Outputs straight from the state register
  assign io_rdata_o = s.rdata;
  assign irq_o      = s.irq;
  assign txd_o      = s.txd;
  assign dtr_n_o    = s.dtr_n;
  assign rts_n_o    = s.rts_n;
  assign out1_n_o   = s.out1_n;
  assign out2_n_o   = s.out2_n;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_data_wr;
    io_wr_i && !io_rd_i && io_addr_i == `ADDR_DATA;
  endsequence
  sequence s_data_rd;
    io_rd_i && io_addr_i == `ADDR_DATA && !s.lcr.divisor_access_select;
  endsequence
  sequence s_status_rd;
    rd_lsr;
  endsequence

  a_thr_write_load:
    assert property (s_data_wr ##0 !s.lcr.divisor_access_select |=> s.thr_full && s.thr == $past(io_wdata_i))
    else $error("holding register not loaded");
  a_rbr_read_data:
    assert property (s_data_rd ##0 buf_out_valid |=> io_rdata_o == $past(buf_out.data))
    else $error("receiver read returned wrong data");
  a_divisor_low_write:
    assert property (s_data_wr ##0 s.lcr.divisor_access_select |=> s.dl_lo == $past(io_wdata_i)
                     && s.thr_full == $past(s.thr_full))
    else $error("divisor low byte write misrouted");
  a_ier_high_zero:
    assert property (rd_ier && !s.lcr.divisor_access_select |=> io_rdata_o[7:4] == 4'h0)
    else $error("interrupt enable upper bits not zero");
  a_iir_none_code:
    assert property (rd_iir && !pend |=> io_rdata_o == 8'h01)
    else $error("idle identification code wrong");
  a_break_low_line:
    assert property (s.lcr.brk [*2] |-> !txd_o)
    else $error("break does not hold line low");
  a_start_bit_low:
    assert property (s.ts == psp_pkg::tx_start && !s.lcr.brk && !s.mcr.loop |=> !txd_o)
    else $error("start bit not low");
  a_status_clear_err:
    assert property (s_status_rd ##0 !rx_push |=> !s.oe && !s.pe && !s.fe && !s.bi)
    else $error("status read left error flags");
  a_overrun_flag:
    assert property (rx_push && !buf_in_ready |=> s.oe)
    else $error("overrun not flagged");
  a_modem_irq_raise:
    assert property (s.ier[3] && |s.msd |=> irq_o)
    else $error("modem delta did not raise interrupt");
  a_msr_read_clear:
    assert property (rd_msr && mdelta == 4'h0 |=> s.msd == 4'h0)
    else $error("modem deltas not cleared by read");

endmodule

// ### hw/psp_defs.svh
`ifndef PSP_DEFS_SVH
`define PSP_DEFS_SVH

// Register addresses on the host I/O port
`define ADDR_DATA 10'h3F8
`define ADDR_IER  10'h3F9
`define ADDR_IIR  10'h3FA
`define ADDR_LCR  10'h3FB
`define ADDR_MCR  10'h3FC
`define ADDR_LSR  10'h3FD
`define ADDR_MSR  10'h3FE

// Reset values
`define DIV_RESET 16'h0001
`define IER_RESET 4'h0
`define MCR_RESET 5'h00
`define MSR_IDLE  4'hF

// Oversampling: sixteen baud ticks per bit
`define BIT_LAST  6'h0F
`define HALF_LAST 4'h7
`define STOP_ONE  6'h10
`define STOP_ONEH 6'h18
`define STOP_TWO  6'h20

// Interrupt identification codes, bits 2:1
`define IID_LINE  2'h3
`define IID_RXDAT 2'h2
`define IID_THRE  2'h1
`define IID_MODEM 2'h0

`endif

// ### hw/psp_pkg.sv
package psp_pkg;

  // Line format control, bit 7 down to bit 0
  typedef struct packed {
    logic       divisor_access_select;
    logic       brk;
    logic       stick;
    logic       even;
    logic       pen;
    logic       stop2;
    logic [1:0] wlen;
  } line_fmt_type;

  // Modem line control, bit 4 down to bit 0
  typedef struct packed {
    logic loop;
    logic out2;
    logic out1;
    logic rts;
    logic dtr;
  } modem_ctl_type;

  // One received character with its status
  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } rx_char_type;

  typedef enum logic [4:0] {
    tx_idle  = 5'h01,
    tx_start = 5'h02,
    tx_data  = 5'h04,
    tx_par   = 5'h08,
    tx_stop  = 5'h10
  } tx_state_type;

  typedef enum logic [4:0] {
    rx_idle  = 5'h01,
    rx_start = 5'h02,
    rx_data  = 5'h04,
    rx_par   = 5'h08,
    rx_stop  = 5'h10
  } rx_state_type;

endpackage

// ### hw/char_buffer.sv
`timescale 1ns/1ps
module char_buffer #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = AW + 1;

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } buf_state_type;

  buf_state_type    s;
  buf_state_type    next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Handshake terms; pointers wrap, so DEPTH is a power of two
  assign in_ready_o  = s.cnt != CW'(DEPTH);
  assign out_valid_o = s.cnt != '0;
  assign out_data_o  = mem[s.rp];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Pointer and fill count update
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.wp = AW'(s.wp + 1'b1);
    end
    if (pop) begin
      next_s.rp = AW'(s.rp + 1'b1);
    end
    next_s.cnt = CW'(s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    if (!rst_n_i) begin
      next_s = '0;
    end
  end

  // State and storage
  always_ff @(posedge clk_i) begin
    s <= next_s;
    if (push) begin
      mem[s.wp] <= in_data_i;
    end
  end

endmodule

// ### dv/serial_peer.sv
`timescale 1ns/1ps
// Far-end serial device: decodes what the port sends and sends frames on request
module serial_peer (
  // Clock
  input  wire logic       clk_i,
  // Serial lines
  input  wire logic       line_i,
  output logic            line_o,
  // Expected character length and last character seen
  input  wire logic [3:0] nbits_i,
  output logic      [7:0] got_o,
  output int              got_cnt_o
);
  int i;

  // Receiver: samples mid-bit, sixteen clocks per bit at divisor one
  initial begin
    line_o = 1'b1;
    got_o = 8'h00;
    got_cnt_o = 0;
    forever begin
      @(negedge line_i);
      repeat (8) @(posedge clk_i);
      got_o = 8'h00;
      for (i = 0; i < nbits_i; i++) begin
        repeat (16) @(posedge clk_i);
        got_o[i] = line_i;
      end
      repeat (16) @(posedge clk_i);
      got_cnt_o++;
    end
  end

  // Sender: start, data LSB first, optional parity bit, one stop bit given by stp
  task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic par,
                      input logic stp);
    logic q[$];
    int   k;
    q = {1'b0};
    for (k = 0; k < nb; k++) q.push_back(d[k]);
    if (pen) q.push_back(par);
    q.push_back(stp);
    @(posedge clk_i);
    for (k = 0; k < q.size(); k++) begin
      #1 line_o = q[k];
      repeat (16) @(posedge clk_i);
    end
    #1 line_o = 1'b1;
  endtask
endmodule

// ### dv/primary_serial_port_tb.sv
`timescale 1ns/1ps
`include "psp_defs.svh"
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("BAD %s expected %h seen %h", nm, ex, gt); end end

module primary_serial_port_tb;
  logic       clk_i, rst_n_i, io_rd_i, io_wr_i, irq_o, txd_o, rxd_i;
  logic       cts_n_i, dsr_n_i, ri_n_i, dcd_n_i, dtr_n_o, rts_n_o, out1_n_o, out2_n_o;
  logic [9:0] io_addr_i;
  logic [7:0] io_wdata_i, io_rdata_o, got;
  logic [3:0] nbits;
  int         got_cnt, n_mismatch, compares, c, w;

  primary_serial_port primary_serial_port_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
    .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .irq_o(irq_o),
    .txd_o(txd_o), .rxd_i(rxd_i), .cts_n_i(cts_n_i), .dsr_n_i(dsr_n_i), .ri_n_i(ri_n_i),
    .dcd_n_i(dcd_n_i), .dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .out1_n_o(out1_n_o),
    .out2_n_o(out2_n_o));

  serial_peer serial_peer_inst (
    .clk_i(clk_i), .line_i(txd_o), .line_o(rxd_i), .nbits_i(nbits), .got_o(got),
    .got_cnt_o(got_cnt));

  // One host write, strobe high for one cycle
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    io_wr_i = 1'b0;
  endtask

  // One host read, compared under a mask
  task automatic rdchk(input logic [9:0] a, input logic [7:0] e, input logic [7:0] m,
                       input string nm);
    @(posedge clk_i);
    #1;
    io_addr_i = a;
    io_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    io_rd_i = 1'b0;
    `CHK(nm, e, io_rdata_o & m)
  endtask

  // Bounded wait for the peer to count n characters
  task automatic wait_rx(input int n);
    for (int k = 0; k < 2000 && got_cnt < n; k++) @(posedge clk_i);
    `CHK("rx_count", 1'b1, got_cnt >= n)
  endtask

  task automatic t_reset;
    rdchk(`ADDR_LSR, 8'h60, 8'hFF, "lsr");
    rdchk(`ADDR_IER, 8'h00, 8'hFF, "ier");
    rdchk(`ADDR_IIR, 8'h01, 8'hFF, "iir");
    rdchk(`ADDR_MCR, 8'h00, 8'hFF, "mcr");
    rdchk(10'h3F0, 8'h00, 8'hFF, "unmapped");
    `CHK("irq", 1'b0, irq_o)
    $display("reset test done");
  endtask

  task automatic t_divisor;
    wr(`ADDR_LCR, 8'h80);
    wr(`ADDR_DATA, 8'h5A);
    wr(`ADDR_IER, 8'hC3);
    rdchk(`ADDR_DATA, 8'h5A, 8'hFF, "div_low");
    rdchk(`ADDR_IER, 8'hC3, 8'hFF, "div_high");
    wr(`ADDR_DATA, 8'h01);
    wr(`ADDR_IER, 8'h00);
    wr(`ADDR_LCR, 8'h03);
    wr(`ADDR_IER, 8'hFF);
    rdchk(`ADDR_IER, 8'h0F, 8'hFF, "ier_bits");
    wr(`ADDR_IER, 8'h00);
    rdchk(`ADDR_LCR, 8'h03, 8'hFF, "lcr");
    $display("divisor test done");
  endtask

  task automatic t_tx;
    for (w = 0; w < 4; w++) begin
      nbits = 4'(5 + w);
      wr(`ADDR_LCR, 8'(w));
      c = got_cnt;
      wr(`ADDR_DATA, 8'h35);
      wait_rx(c + 1);
      `CHK("tx_char", 8'h35 & 8'((1 << (5 + w)) - 1), got)
      repeat (24) @(posedge clk_i);
      rdchk(`ADDR_LSR, 8'h60, 8'hFF, "lsr_idle");
    end
    c = got_cnt;
    wr(`ADDR_DATA, 8'hC3);
    repeat (20) @(posedge clk_i);
    wr(`ADDR_DATA, 8'h3C);
    rdchk(`ADDR_LSR, 8'h00, 8'h60, "lsr_busy");
    wait_rx(c + 2);
    `CHK("tx_second", 8'h3C, got)
    $display("transmit test done");
  endtask

  task automatic t_rx_err;
    wr(`ADDR_LCR, 8'h1B);
    wr(`ADDR_IER, 8'h05);
    serial_peer_inst.send(8'h01, 8, 1'b1, 1'b0, 1'b1);
    rdchk(`ADDR_IIR, 8'h06, 8'hFF, "iir_line");
    `CHK("irq_on", 1'b1, irq_o)
    rdchk(`ADDR_LSR, 8'h65, 8'hFF, "lsr_pe");
    rdchk(`ADDR_IIR, 8'h04, 8'hFF, "iir_rx");
    rdchk(`ADDR_DATA, 8'h01, 8'hFF, "rx_pe");
    rdchk(`ADDR_IIR, 8'h01, 8'hFF, "iir_none");
    serial_peer_inst.send(8'h80, 8, 1'b1, 1'b1, 1'b0);
    rdchk(`ADDR_LSR, 8'h69, 8'hFF, "lsr_fe");
    rdchk(`ADDR_DATA, 8'h80, 8'hFF, "rx_fe");
    serial_peer_inst.send(8'h00, 8, 1'b1, 1'b0, 1'b0);
    rdchk(`ADDR_LSR, 8'h10, 8'h10, "lsr_brk");
    rdchk(`ADDR_DATA, 8'h00, 8'hFF, "rx_brk");
    rdchk(`ADDR_LSR, 8'h60, 8'hFF, "lsr_clr");
    wr(`ADDR_IER, 8'h00);
    $display("receive error test done");
  endtask

  task automatic t_overrun;
    wr(`ADDR_LCR, 8'h03);
    serial_peer_inst.send(8'hA1, 8, 1'b0, 1'b0, 1'b1);
    serial_peer_inst.send(8'hA2, 8, 1'b0, 1'b0, 1'b1);
    serial_peer_inst.send(8'hA3, 8, 1'b0, 1'b0, 1'b1);
    rdchk(`ADDR_LSR, 8'h63, 8'hFF, "lsr_or");
    rdchk(`ADDR_DATA, 8'hA1, 8'hFF, "rx_first");
    rdchk(`ADDR_DATA, 8'hA2, 8'hFF, "rx_second");
    rdchk(`ADDR_LSR, 8'h60, 8'hFF, "lsr_empty");
    $display("overrun test done");
  endtask

  task automatic t_thr_irq;
    wr(`ADDR_IER, 8'h02);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("irq_thr", 1'b1, irq_o)
    rdchk(`ADDR_IIR, 8'h02, 8'hFF, "iir_thr");
    rdchk(`ADDR_IIR, 8'h01, 8'hFF, "iir_thr_clr");
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("irq_off", 1'b0, irq_o)
    wr(`ADDR_IER, 8'h00);
    $display("holding empty test done");
  endtask

  task automatic t_modem;
    wr(`ADDR_MCR, 8'h0F);
    rdchk(`ADDR_MCR, 8'h0F, 8'hFF, "mcr_all");
    `CHK("pins_on", 4'h0, {out2_n_o, out1_n_o, rts_n_o, dtr_n_o})
    wr(`ADDR_MCR, 8'hE2);
    rdchk(`ADDR_MCR, 8'h02, 8'hFF, "mcr_rts");
    `CHK("pins_rts", 4'hD, {out2_n_o, out1_n_o, rts_n_o, dtr_n_o})
    {dcd_n_i, ri_n_i, dsr_n_i, cts_n_i} = 4'h0;
    repeat (4) @(posedge clk_i);
    rdchk(`ADDR_MSR, 8'h0B, 8'hFF, "msr_delta");
    rdchk(`ADDR_MSR, 8'h00, 8'hFF, "msr_clr");
    wr(`ADDR_IER, 8'h08);
    cts_n_i = 1'b1;
    repeat (4) @(posedge clk_i);
    rdchk(`ADDR_IIR, 8'h00, 8'hFF, "iir_modem");
    rdchk(`ADDR_MSR, 8'h11, 8'hFF, "msr_rise");
    rdchk(`ADDR_IIR, 8'h01, 8'hFF, "iir_modem_clr");
    wr(`ADDR_IER, 8'h00);
    {dcd_n_i, ri_n_i, dsr_n_i} = 3'h7;
    repeat (4) @(posedge clk_i);
    rdchk(`ADDR_MSR, 8'hFE, 8'hFF, "msr_trail");
    wr(`ADDR_MCR, 8'h00);
    $display("modem test done");
  endtask

  // Break, loopback with odd parity and two stops, then a reset in mid-run
  task automatic t_loop;
    wr(`ADDR_LCR, 8'h43);
    repeat (3) @(posedge clk_i);
    #1;
    `CHK("txd_brk", 1'b0, txd_o)
    wr(`ADDR_LCR, 8'h0F);
    wr(`ADDR_MCR, 8'h1F);
    rdchk(`ADDR_MSR, 8'h0B, 8'hFF, "msr_loop");
    `CHK("pins_loop", 4'hF, {out2_n_o, out1_n_o, rts_n_o, dtr_n_o})
    wr(`ADDR_DATA, 8'h5B);
    repeat (183) @(posedge clk_i);
    rdchk(`ADDR_LSR, 8'h00, 8'h40, "lsr_stop2");
    `CHK("txd_loop", 1'b1, txd_o)
    repeat (16) @(posedge clk_i);
    rdchk(`ADDR_LSR, 8'h61, 8'hFF, "lsr_loop");
    rdchk(`ADDR_DATA, 8'h5B, 8'hFF, "rx_loop");
    wr(`ADDR_MCR, 8'h10);
    rdchk(`ADDR_MSR, 8'hFF, 8'hFF, "msr_loop_off");
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    rdchk(`ADDR_LCR, 8'h00, 8'hFF, "lcr_rst");
    rdchk(`ADDR_MCR, 8'h00, 8'hFF, "mcr_rst");
    rdchk(`ADDR_MSR, 8'hF0, 8'hFF, "msr_rst");
    $display("loopback test done");
  endtask

  // Closing verdict
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Clock, 20 ns period
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Watchdog against a hang
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    {rst_n_i, io_rd_i, io_wr_i, io_addr_i, io_wdata_i} = '0;
    {cts_n_i, dsr_n_i, ri_n_i, dcd_n_i} = 4'hF;
    nbits = 4'h8;
    n_mismatch = 0;
    compares = 0;
    repeat (10) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_reset;
    t_divisor;
    t_tx;
    t_rx_err;
    t_overrun;
    t_thr_irq;
    t_modem;
    t_loop;
    report_and_stop;
  end
endmodule
